//--- hw/tape_motion_state_machine.sv
`timescale 1ns/100ps
`default_nettype none
// ==========================================================================
module tape_motion_state_machine (
   // clock and reset
   input  wire logic                       clk,
   input  wire logic                       rst_n,
   input  wire logic                       clk_en,
   // interlock ready, low clears the state
   input  wire logic                       interlock_ready_clear,
   // host commands (pins)
   input  wire tape_motion_pkg::host_cmd_t cmd_pins,
   // tape sensing (pins)
   input  wire tape_motion_pkg::tape_stat_t stat_pins,
   // decoded servo and status outputs
   output tape_motion_pkg::servo_out_t     servo,
   // current state code
   output logic [3:0]                      state_code
);

   // all state of the block
   typedef struct packed {
      tape_motion_pkg::host_cmd_t    cmd_s1;
      tape_motion_pkg::host_cmd_t    cmd_s2;
      tape_motion_pkg::tape_stat_t   stat_s1;
      tape_motion_pkg::tape_stat_t   stat_s2;
      logic                          ilk_s1;
      logic                          ilk_s2;
      logic                          present_d;
      tape_motion_pkg::motion_state_t state;
      tape_motion_pkg::servo_out_t   outs;
   } core_t;

   localparam core_t CORE_RESET = '{
      cmd_s1: '0, cmd_s2: '0, stat_s1: '0, stat_s2: '0,
      ilk_s1: 1'b0, ilk_s2: 1'b0, present_d: 1'b0,
      state: tape_motion_pkg::RESET_STATE,
      outs: tape_motion_pkg::OUT_RESET};

   core_t                          core_ff;
   core_t                          nxt_core;
   tape_motion_pkg::servo_out_t    dec_next;
   tape_motion_pkg::host_cmd_t     c;
   tape_motion_pkg::tape_stat_t    s;
   logic                           removed;

   // run request decode: returns target run state or stop if none
   function automatic tape_motion_pkg::motion_state_t run_target(
      input tape_motion_pkg::host_cmd_t hc,
      input logic allow_fwd,
      input logic allow_rev);
      run_target = tape_motion_pkg::st_stop;
      if (hc.select && hc.run_command) begin
         if (hc.forward_request && allow_fwd)
            run_target = hc.slow_request ? tape_motion_pkg::st_slow_fwd
                                         : tape_motion_pkg::st_fast_fwd;
         else if (hc.reverse_request && allow_rev)
            run_target = hc.slow_request ? tape_motion_pkg::st_slow_rev
                                         : tape_motion_pkg::st_fast_rev;
      end
   endfunction

   // output decode of the next state so outputs register with the state
   tape_output_decode tape_output_decode_i (
      .state (nxt_core.state),
      .dec   (dec_next)
   );

   // next state logic
   always_comb begin
      nxt_core = core_ff;
      c = core_ff.cmd_s2;
      s = core_ff.stat_s2;
      nxt_core.cmd_s1 = cmd_pins;
      nxt_core.cmd_s2 = core_ff.cmd_s1;
      nxt_core.stat_s1 = stat_pins;
      nxt_core.stat_s2 = core_ff.stat_s1;
      nxt_core.ilk_s1 = interlock_ready_clear;
      nxt_core.ilk_s2 = core_ff.ilk_s1;
      nxt_core.present_d = s.cartridge_present;
      removed = core_ff.present_d && !s.cartridge_present;
      unique case (core_ff.state)
         tape_motion_pkg::st_stop: begin
            if (!s.cartridge_present)
               nxt_core.state = tape_motion_pkg::st_empty;
            else if (run_target(c, 1'b1, 1'b1) != tape_motion_pkg::st_stop)
               nxt_core.state = run_target(c, 1'b1, 1'b1);
         end
         tape_motion_pkg::st_fast_fwd,
         tape_motion_pkg::st_slow_fwd: begin
            if (s.end_of_tape_pulse)
               nxt_core.state = tape_motion_pkg::st_stop_eot;
            else if (!c.run_command)
               nxt_core.state = tape_motion_pkg::st_stop;
         end
         tape_motion_pkg::st_fast_rev,
         tape_motion_pkg::st_slow_rev: begin
            if (s.beginning_of_tape_pulse)
               nxt_core.state = tape_motion_pkg::st_stop_bot;
            else if (!c.run_command)
               nxt_core.state = tape_motion_pkg::st_stop;
         end
         tape_motion_pkg::st_stop_eot: begin
            if (c.automatic_unload_enable || c.unload_command)
               nxt_core.state = tape_motion_pkg::st_unload_fr;
            else if (c.rewind_command)
               nxt_core.state = tape_motion_pkg::st_rewind_fr;
            else if (run_target(c, 1'b0, 1'b1) != tape_motion_pkg::st_stop)
               nxt_core.state = run_target(c, 1'b0, 1'b1);
         end
         tape_motion_pkg::st_stop_bot: begin
            if (c.unload_command)
               nxt_core.state = tape_motion_pkg::st_unload_fr;
            else if (c.rewind_command)
               nxt_core.state = tape_motion_pkg::st_rewind_fr;
            else if (run_target(c, 1'b1, 1'b0) != tape_motion_pkg::st_stop)
               nxt_core.state = run_target(c, 1'b1, 1'b0);
         end
         tape_motion_pkg::st_empty: begin
            if (s.cartridge_present)
               nxt_core.state = tape_motion_pkg::st_rewind_fr;
         end
         tape_motion_pkg::st_rewind_fr: begin
            if (s.beginning_of_tape_pulse)
               nxt_core.state = tape_motion_pkg::st_load_sf;
         end
         tape_motion_pkg::st_load_sf: begin
            if (s.load_point_pulse)
               nxt_core.state = tape_motion_pkg::st_stop_lp;
         end
         tape_motion_pkg::st_stop_lp: begin
            if (c.unload_command)
               nxt_core.state = tape_motion_pkg::st_unload_fr;
            else if (run_target(c, 1'b1, 1'b1) != tape_motion_pkg::st_stop)
               nxt_core.state = run_target(c, 1'b1, 1'b1);
         end
         tape_motion_pkg::st_unload_fr: begin
            if (s.beginning_of_tape_pulse)
               nxt_core.state = tape_motion_pkg::st_decel_wait;
         end
         tape_motion_pkg::st_decel_wait:
            nxt_core.state = tape_motion_pkg::st_eject;
         tape_motion_pkg::st_eject:
            nxt_core.state = tape_motion_pkg::st_stop;
         default: nxt_core.state = tape_motion_pkg::st_stop;           // illegal codes
      endcase
      // cartridge pulled outside eject, or interlock open, forces stop
      if (removed && core_ff.state != tape_motion_pkg::st_eject)
         nxt_core.state = tape_motion_pkg::st_stop;
      if (!core_ff.ilk_s2)
         nxt_core.state = tape_motion_pkg::st_stop;
      nxt_core.outs = dec_next;
   end

   // state register
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         core_ff <= CORE_RESET;
      end else if (clk_en) begin
         core_ff <= nxt_core;
      end
   end

   assign servo = core_ff.outs;
   assign state_code = core_ff.state;

endmodule // tape_motion_state_machine
`default_nettype wire

//--- hw/tape_motion_pkg.sv
// ==========================================================================
// shared types and constants for the tape motion controller
package tape_motion_pkg;

   // state codes, four flip-flop bits
   typedef enum logic [3:0] {
      st_stop          = 4'h0,
      st_fast_fwd      = 4'h8,
      st_slow_fwd      = 4'h4,
      st_fast_rev      = 4'h2,
      st_slow_rev      = 4'h1,
      st_stop_eot      = 4'hc,
      st_stop_bot      = 4'h3,
      st_empty         = 4'ha,
      st_rewind_fr     = 4'he,
      st_load_sf       = 4'h7,
      st_stop_lp       = 4'h6,
      st_unload_fr     = 4'hd,
      st_decel_wait    = 4'hb,
      st_eject         = 4'h9
   } motion_state_t;

   localparam motion_state_t RESET_STATE = st_stop;

   // commands from the host
   typedef struct packed {
      logic select;
      logic run_command;
      logic slow_request;
      logic forward_request;
      logic reverse_request;
      logic rewind_command;
      logic unload_command;
      logic automatic_unload_enable;
   } host_cmd_t;

   // status from the tape sensing logic (pulses except cartridge_present)
   typedef struct packed {
      logic cartridge_present;
      logic beginning_of_tape_pulse;
      logic end_of_tape_pulse;
      logic load_point_pulse;
   } tape_stat_t;

   // decoded outputs
   typedef struct packed {
      logic servo_drive_out;
      logic servo_forward_latch_out;
      logic servo_reverse_out;
      logic servo_high_speed_out;
      logic servo_slow_out;
      logic eject_out;
      logic write_inhibit_out;
      logic busy_out;
      logic at_load_point_out;
      logic at_end_of_tape_out;
   } servo_out_t;

   localparam int OUT_W = 10;

   // all outputs inactive
   localparam servo_out_t OUT_RESET = servo_out_t'(10'h000);

endpackage

//--- hw/tape_output_decode.sv
`timescale 1ns/100ps
`default_nettype none
// ==========================================================================
// pure state decode of servo and status lines
module tape_output_decode (
   // current state
   input  wire tape_motion_pkg::motion_state_t state,
   // decoded lines
   output tape_motion_pkg::servo_out_t         dec
);

   // lookup by state code; write inhibit in every state
   always_comb begin
      dec = tape_motion_pkg::OUT_RESET;
      dec.write_inhibit_out = 1'b1;
      unique case (state)
         tape_motion_pkg::st_fast_fwd: begin
            dec.servo_drive_out = 1'b1;
            dec.servo_forward_latch_out = 1'b1;
            dec.servo_high_speed_out = 1'b1;
         end
         tape_motion_pkg::st_slow_fwd: begin
            dec.servo_drive_out = 1'b1;
            dec.servo_forward_latch_out = 1'b1;
            dec.servo_slow_out = 1'b1;
         end
         tape_motion_pkg::st_fast_rev: begin
            dec.servo_drive_out = 1'b1;
            dec.servo_reverse_out = 1'b1;
            dec.servo_high_speed_out = 1'b1;
         end
         tape_motion_pkg::st_slow_rev: begin
            dec.servo_drive_out = 1'b1;
            dec.servo_reverse_out = 1'b1;
            dec.servo_slow_out = 1'b1;
         end
         tape_motion_pkg::st_stop_eot: dec.at_end_of_tape_out = 1'b1;
         tape_motion_pkg::st_rewind_fr,
         tape_motion_pkg::st_unload_fr: begin
            dec.servo_drive_out = 1'b1;
            dec.servo_reverse_out = 1'b1;
            dec.servo_high_speed_out = 1'b1;
            dec.busy_out = 1'b1;
         end
         tape_motion_pkg::st_load_sf: begin
            dec.servo_drive_out = 1'b1;
            dec.servo_forward_latch_out = 1'b1;
            dec.servo_slow_out = 1'b1;
            dec.busy_out = 1'b1;
         end
         tape_motion_pkg::st_stop_lp: dec.at_load_point_out = 1'b1;
         tape_motion_pkg::st_eject: dec.eject_out = 1'b1;
         default: dec.write_inhibit_out = 1'b1;  // stop, bot, empty, decel
      endcase
   end

endmodule // tape_output_decode
`default_nettype wire

//--- tb/tape_motion_properties.sv
`timescale 1ns/100ps
`default_nettype none
// ==========================================================================
// port-level checks of the tape motion controller
module tape_motion_properties (
   // clock and reset
   input wire logic                        clk,
   input wire logic                        rst_n,
   input wire logic                        clk_en,
   // interlock pin
   input wire logic                        interlock_ready_clear,
   // observed outputs
   input wire tape_motion_pkg::servo_out_t servo,
   input wire logic [3:0]                  state_code
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   // stop after every reset release and after an open interlock
   property p_reset_stop; $rose(rst_n) |-> state_code == 4'h0; endproperty
   a_reset_stop: assert property (p_reset_stop) else $error("state not stop after reset");
   property p_interlock; (!interlock_ready_clear && clk_en) [*3] |=> state_code == 4'h0; endproperty
   a_interlock: assert property (p_interlock) else $error("open interlock did not stop");
   // decoded outputs follow the state alone
   property p_stop_out; $past(rst_n) && state_code == 4'h0 |-> servo == 10'h008; endproperty
   a_stop_out: assert property (p_stop_out) else $error("stop outputs wrong");
   property p_slow_fwd; state_code == 4'h4 |-> servo.servo_drive_out && servo.servo_forward_latch_out && servo.servo_slow_out; endproperty
   a_slow_fwd: assert property (p_slow_fwd) else $error("slow forward outputs wrong");
   property p_decode; $past(rst_n, 2) && $stable(state_code) |-> $stable(servo); endproperty
   a_decode: assert property (p_decode) else $error("outputs moved with state held");
   // refused motions at the tape ends and load point; eject ends in stop
   property p_eot_refuse; state_code == 4'hc |=> state_code != 4'h8 && state_code != 4'h4; endproperty
   a_eot_refuse: assert property (p_eot_refuse) else $error("forward left end stop");
   property p_bot_refuse; state_code == 4'h3 |=> state_code != 4'h2 && state_code != 4'h1; endproperty
   a_bot_refuse: assert property (p_bot_refuse) else $error("reverse left start stop");
   property p_lp_rewind; state_code == 4'h6 |=> state_code != 4'he; endproperty
   a_lp_rewind: assert property (p_lp_rewind) else $error("rewind taken at load point");
   property p_eject_stop; state_code == 4'h9 && clk_en |=> state_code == 4'h0; endproperty
   a_eject_stop: assert property (p_eject_stop) else $error("eject did not end in stop");
endmodule // tape_motion_properties

bind tape_motion_state_machine tape_motion_properties tape_motion_properties_i (
   .clk(clk), .rst_n(rst_n), .clk_en(clk_en), .interlock_ready_clear(interlock_ready_clear),
   .servo(servo), .state_code(state_code));
`default_nettype wire

//--- tb/tape_sense_model.sv
`timescale 1ns/100ps
`default_nettype none
// ==========================================================================
// tape sensing side: cartridge level and single-cycle marks
module tape_sense_model (
   // clock
   input  wire logic                      clk,
   // status toward the controller
   output var tape_motion_pkg::tape_stat_t stat
);
   // cartridge loaded, no marks at start
   initial stat = 4'h8;
   // cartridge level changes between edges
   task automatic set_cartridge(input logic v);
      @(negedge clk) stat.cartridge_present = v;
   endtask
   // marks are one-cycle pulses, never levels
   task automatic pulse(input int idx);
      @(negedge clk) stat[idx] = 1'b1;
      @(negedge clk) stat[idx] = 1'b0;
   endtask
endmodule // tape_sense_model
`default_nettype wire

//--- tb/tape_motion_state_machine_bench.sv
`timescale 1ns/100ps
`default_nettype none
// ==========================================================================
// self-checking bench of the tape motion controller
module tape_motion_state_machine_bench;
   logic                        clk;
   logic                        rst_n;
   logic                        clk_en;
   logic                        ilk;
   tape_motion_pkg::host_cmd_t  cmd;
   tape_motion_pkg::tape_stat_t stat;
   tape_motion_pkg::servo_out_t servo;
   logic [3:0]                  state_code;
   int                          num_errors = 0;
   int                          n_checks = 0;
   int                          cycles = 0;
   logic [7:0]                  runs [4] = '{8'hf0, 8'hd0, 8'he8, 8'hc8};
   logic [3:0]                  codes [4] = '{4'h4, 4'h8, 4'h1, 4'h2};
   logic [9:0]                  outs [4] = '{10'h328, 10'h348, 10'h2a8, 10'h2c8};

   tape_motion_state_machine tape_motion_state_machine_i (.clk(clk), .rst_n(rst_n), .clk_en(clk_en),
      .interlock_ready_clear(ilk), .cmd_pins(cmd), .stat_pins(stat), .servo(servo), .state_code(state_code));
   tape_sense_model tape_sense_model_i (.clk(clk), .stat(stat));

   // 100 MHz clock
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   // hang guard
   always @(posedge clk) begin
      cycles++;
      if (cycles == 5000) begin
         num_errors++;
         $display("BAD %0t timeout", $time);
         print_verdict();
      end
   end

   // ==========================================================================
   // access tasks
   task automatic drive(input logic [7:0] c);
      @(negedge clk) cmd = c;
   endtask
   task automatic expect_state(input logic [3:0] s, input logic [9:0] o, input logic chk_o);
      int n;
      n = 0;
      while (state_code !== s && n < 12) begin
         @(negedge clk);
         n++;
      end
      n_checks++;
      if (state_code !== s || (chk_o && servo !== o)) begin
         num_errors++;
         $display("BAD %0t state %h servo %h want %h %h", $time, state_code, servo, s, o);
      end
   endtask
   task automatic hold(input logic [3:0] s);
      repeat (8) @(negedge clk);
      expect_state(s, 10'h000, 1'b0);
   endtask
   task automatic print_verdict();
      $display("checks %0d errors %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask

   // ==========================================================================
   // main sequence
   initial begin
      rst_n = 1'b0;
      clk_en = 1'b1;
      ilk = 1'b1;
      cmd = 8'h00;
      repeat (20) @(negedge clk);
      rst_n = 1'b1;
      // outputs leave their reset value only at the first enabled edge
      repeat (2) @(negedge clk);
      expect_state(4'h0, 10'h008, 1'b1);
      drive(8'hf0); expect_state(4'h4, 10'h328, 1'b1);
      drive(8'h00); expect_state(4'h0, 10'h008, 1'b1);
      for (int i = 0; i < 4; i++) begin
         drive(runs[i]); expect_state(codes[i], outs[i], 1'b1);
         drive(8'h00); expect_state(4'h0, 10'h008, 1'b1);
      end
      drive(8'hd0); expect_state(4'h8, 10'h000, 1'b0);
      tape_sense_model_i.pulse(1); expect_state(4'hc, 10'h009, 1'b1);
      drive(8'h00); hold(4'hc);
      drive(8'hf0); hold(4'hc);
      drive(8'h01); expect_state(4'hd, 10'h2cc, 1'b1);
      tape_sense_model_i.pulse(2); expect_state(4'hb, 10'h008, 1'b1);
      expect_state(4'h9, 10'h018, 1'b1);
      expect_state(4'h0, 10'h008, 1'b1);
      drive(8'he8); expect_state(4'h1, 10'h000, 1'b0);
      tape_sense_model_i.pulse(2); expect_state(4'h3, 10'h008, 1'b1);
      hold(4'h3);
      drive(8'h84); expect_state(4'he, 10'h2cc, 1'b1);
      drive(8'h00); tape_sense_model_i.pulse(2); expect_state(4'h7, 10'h32c, 1'b1);
      tape_sense_model_i.pulse(0); expect_state(4'h6, 10'h00a, 1'b1);
      drive(8'h84); hold(4'h6);
      drive(8'hf0); expect_state(4'h4, 10'h328, 1'b1);
      tape_sense_model_i.set_cartridge(1'b0); expect_state(4'h0, 10'h008, 1'b1);
      expect_state(4'ha, 10'h008, 1'b1);
      drive(8'h00); tape_sense_model_i.set_cartridge(1'b1); expect_state(4'he, 10'h2cc, 1'b1);
      @(negedge clk) ilk = 1'b0;
      expect_state(4'h0, 10'h008, 1'b1);
      @(negedge clk) clk_en = 1'b0;
      ilk = 1'b1;
      drive(8'hf0); hold(4'h0);
      @(negedge clk) clk_en = 1'b1;
      expect_state(4'h4, 10'h328, 1'b1);
      @(negedge clk) rst_n = 1'b0;
      expect_state(4'h0, 10'h000, 1'b1);
      @(negedge clk) rst_n = 1'b1;
      // second release: stop for two edges, then the held run command is taken
      repeat (2) @(negedge clk);
      expect_state(4'h0, 10'h008, 1'b1);
      expect_state(4'h4, 10'h328, 1'b1);
      drive(8'h00); expect_state(4'h0, 10'h008, 1'b1);
      // run without select is refused
      drive(8'h50); hold(4'h0);
      // unload command from the start-of-tape stop
      drive(8'he8); expect_state(4'h1, 10'h2a8, 1'b1);
      tape_sense_model_i.pulse(2); expect_state(4'h3, 10'h008, 1'b1);
      drive(8'h82); expect_state(4'hd, 10'h2cc, 1'b1);
      drive(8'h00); tape_sense_model_i.pulse(2); expect_state(4'hb, 10'h008, 1'b1);
      expect_state(4'h9, 10'h018, 1'b1);
      expect_state(4'h0, 10'h008, 1'b1);
      print_verdict();
   end
endmodule // tape_motion_state_machine_bench
`default_nettype wire
